// ### pkg/ccie_pkg.sv
// Constants, opcode patterns and types for the call and clear execution block.
// Assumes a single core clock and a synchronous active-high core reset.
// Overview of operation
// RQ1 - A call first pushes the address after the call, the program counter plus one, onto the stack top.
// RQ2 - A call loads its 8-bit immediate into the low eight program counter bits.
// RQ3 - A call copies status page bits six and five into program counter bits ten and nine.
// RQ4 - A call forces program counter bit eight to zero.
// RQ5 - A call takes two instruction cycles and leaves every status flag alone.
// RQ6 - The file clear writes zero to the addressed data register 0 to 31 and sets the zero flag.
// RQ7 - The accumulator clear writes zero to the accumulator and sets the zero flag.
// RQ8 - Calls, file clears and accumulator clears are decoded from fixed patterns; both clears take one cycle.
package ccie_pkg;
   localparam int INSTR_W = 12;
   localparam int PROG_CNT_W = 11;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int STACK_DEPTH = 4;
   localparam logic [PROG_CNT_W-1:0] PROG_CNT_RESET = 11'h000;
   localparam logic [PROG_CNT_W-1:0] PROG_CNT_STEP = 11'h001;
   localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
   // Call: top nibble, immediate in low byte
   localparam logic [3:0] CALL_NIBBLE = 4'h9;
   localparam int CALL_TOP = 11;
   localparam int CALL_BOT = 8;
   localparam int IMM_TOP = 7;
   // File clear: seven fixed bits above a 5-bit address
   localparam logic [6:0] CLR_FILE_PATTERN = 7'h03;
   localparam int CLR_FILE_TOP = 11;
   localparam int CLR_FILE_BOT = 5;
   localparam int FADDR_TOP = 4;
   // Accumulator clear: whole word
   localparam logic [INSTR_W-1:0] CLR_ACC_WORD = 12'h040;
   localparam int PROG_CNT_ZERO_BIT = 8;
   typedef enum logic [1:0] {
      CCIE_OP_OTHER,
      CCIE_OP_CALL,
      CCIE_OP_CLEAR_FILE,
      CCIE_OP_CLEAR_ACC
   } ccie_op_t;
endpackage

// ### pkg/ccie_stack_if.sv
// Push port between the execution core and its return stack.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface ccie_stack_if;
   logic push;
   logic [ccie_pkg::PROG_CNT_W-1:0] push_addr;
   logic [ccie_pkg::PROG_CNT_W-1:0] top;
   modport core (output push, output push_addr, input top);
   modport stack (input push, input push_addr, output top);
endinterface
`default_nettype wire

// ### hw/ccie_stack.sv
// Hardware return stack; pushes shift older entries down, the deepest is lost.
// Assumes pushes come from logic on the same clock; pops belong to other instructions.
`timescale 1ns/1ps
`default_nettype none
module ccie_stack (
   input wire logic core_clk,
   input wire logic sys_rst,
   ccie_stack_if.stack port
);
   logic [ccie_pkg::PROG_CNT_W-1:0] level [ccie_pkg::STACK_DEPTH];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < ccie_pkg::STACK_DEPTH; i++) begin
            level[i] <= ccie_pkg::PROG_CNT_RESET;
         end
      end else if (port.push) begin
         level[0] <= port.push_addr;
         for (int i = 1; i < ccie_pkg::STACK_DEPTH; i++) begin
            level[i] <= level[i-1];
         end
      end
   end

   assign port.top = level[0];
endmodule
`default_nettype wire

// ### hw/ccie_exec.sv
// Execution of subroutine call, file clear and accumulator clear.
// Assumes the fetch side holds instr_word with instr_valid until busy is low,
// and that register file, accumulator and status flags sit outside.
`timescale 1ns/1ps
`default_nettype none
module ccie_exec (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [ccie_pkg::INSTR_W-1:0] instr_word,
   input wire logic [1:0] status_page,
   output logic [ccie_pkg::PROG_CNT_W-1:0] program_counter,
   output logic [ccie_pkg::PROG_CNT_W-1:0] stack_top,
   output logic busy,
   output logic call_done,
   output logic file_wr_en,
   output logic [ccie_pkg::FADDR_W-1:0] file_wr_addr,
   output logic [ccie_pkg::DATA_W-1:0] file_wr_data,
   output logic acc_wr_en,
   output logic [ccie_pkg::DATA_W-1:0] acc_wr_data,
   output logic zero_set
);
   typedef enum logic {CCIE_ST_EXEC, CCIE_ST_CALL2} ccie_state_t;

   ccie_state_t state;
   ccie_pkg::ccie_op_t op;
   logic take;
   logic [ccie_pkg::PROG_CNT_W-1:0] next_program_counter;
   ccie_stack_if stk ();

   assign take = instr_valid && (state == CCIE_ST_EXEC);

   // RQ8 opcode decode
   always_comb begin
      if (instr_word[ccie_pkg::CALL_TOP:ccie_pkg::CALL_BOT] == ccie_pkg::CALL_NIBBLE) begin
         op = ccie_pkg::CCIE_OP_CALL;
      end else if (instr_word == ccie_pkg::CLR_ACC_WORD) begin
         op = ccie_pkg::CCIE_OP_CLEAR_ACC;
      end else if (instr_word[ccie_pkg::CLR_FILE_TOP:ccie_pkg::CLR_FILE_BOT] == ccie_pkg::CLR_FILE_PATTERN) begin
         op = ccie_pkg::CCIE_OP_CLEAR_FILE;
      end else begin
         op = ccie_pkg::CCIE_OP_OTHER;
      end
   end

   // RQ2 RQ3 RQ4 call target build
   always_comb begin
      if (op == ccie_pkg::CCIE_OP_CALL) begin
         // Page bits from status; bit eight low keeps targets in the lower half of a page
         next_program_counter = {status_page, 1'b0, instr_word[ccie_pkg::IMM_TOP:0]};
      end else begin
         next_program_counter = program_counter + ccie_pkg::PROG_CNT_STEP;
      end
   end

   // RQ5 RQ8 counter update
   // Moves only on a taken word, so a stalled call never steps twice
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         program_counter <= ccie_pkg::PROG_CNT_RESET;
      end else if (take) begin
         program_counter <= next_program_counter;
      end
   end

   // RQ5 two-cycle call
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= CCIE_ST_EXEC;
         busy <= 1'b0;
         call_done <= 1'b0;
      end else begin
         call_done <= 1'b0;
         case (state)
            CCIE_ST_EXEC: begin
               if (take && op == ccie_pkg::CCIE_OP_CALL) begin
                  state <= CCIE_ST_CALL2;
                  busy <= 1'b1;
               end
            end
            CCIE_ST_CALL2: begin
               state <= CCIE_ST_EXEC;
               busy <= 1'b0;
               call_done <= 1'b1;
            end
            default: begin
               state <= CCIE_ST_EXEC;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // RQ1 return address push
   assign stk.push = take && (op == ccie_pkg::CCIE_OP_CALL);
   assign stk.push_addr = program_counter + ccie_pkg::PROG_CNT_STEP;

   ccie_stack u_ccie_stack (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .port(stk)
   );

   // Registered copy so the output comes from a flop of this module
   // The stack's own top is held against this copy by an assertion below
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stack_top <= ccie_pkg::PROG_CNT_RESET;
      end else if (stk.push) begin
         stack_top <= stk.push_addr;
      end
   end

   // RQ6 file clear write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         file_wr_en <= 1'b0;
         file_wr_addr <= '0;
         file_wr_data <= ccie_pkg::ZERO_DATA;
      end else begin
         file_wr_en <= take && (op == ccie_pkg::CCIE_OP_CLEAR_FILE);
         file_wr_data <= ccie_pkg::ZERO_DATA;
         // Address holds between clears so a slow register file can still latch it
         if (take && op == ccie_pkg::CCIE_OP_CLEAR_FILE) begin
            file_wr_addr <= instr_word[ccie_pkg::FADDR_TOP:0];
         end
      end
   end

   // RQ7 accumulator clear write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         acc_wr_en <= 1'b0;
         acc_wr_data <= ccie_pkg::ZERO_DATA;
      end else begin
         acc_wr_en <= take && (op == ccie_pkg::CCIE_OP_CLEAR_ACC);
         acc_wr_data <= ccie_pkg::ZERO_DATA;
      end
   end

   // RQ5 RQ6 RQ7 zero flag set
   // Only the clears raise it; a call must leave the status flags alone
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         zero_set <= 1'b0;
      end else begin
         zero_set <= take && (op == ccie_pkg::CCIE_OP_CLEAR_FILE || op == ccie_pkg::CCIE_OP_CLEAR_ACC);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_call_taken;
      take && op == ccie_pkg::CCIE_OP_CALL;
   endsequence

   sequence s_call_second;
      busy && !call_done ##1 !busy && call_done;
   endsequence

   sequence s_file_clear_taken;
      take && op == ccie_pkg::CCIE_OP_CLEAR_FILE;
   endsequence

   sequence s_acc_clear_taken;
      take && instr_word == ccie_pkg::CLR_ACC_WORD;
   endsequence

   sequence s_zero_written;
      zero_set && !busy && !call_done;
   endsequence

   // Call checks
   a_call_push_addr: assert property (s_call_taken |=> stack_top == $past(program_counter) + 11'h001) // RQ1
      else $error("Return address not pushed");
   a_call_low_byte: assert property (s_call_taken |=> program_counter[7:0] == $past(instr_word[7:0])) // RQ2
      else $error("Call immediate not loaded");
   a_call_page_bits: assert property (s_call_taken |=> program_counter[10:9] == $past(status_page)) // RQ3
      else $error("Page bits not copied");
   a_call_bit_eight: assert property (s_call_taken |=> !program_counter[ccie_pkg::PROG_CNT_ZERO_BIT]) // RQ4
      else $error("Program counter bit eight not cleared");
   a_call_two_cycles: assert property (s_call_taken |=> s_call_second) // RQ5
      else $error("Call did not take two cycles");
   a_call_no_flags: assert property (s_call_taken |=> !zero_set ##1 !zero_set) // RQ5
      else $error("Call touched a status flag");
   a_stack_top_copy: assert property (stack_top == stk.top) // RQ1
      else $error("Stack top copy differs from the stack");
   a_push_only_call: assert property (!(take && op == ccie_pkg::CCIE_OP_CALL) |=> $stable(stack_top)) // RQ1
      else $error("Stack top moved without a call");
   a_call_done_pulse: assert property (call_done |=> !call_done) // RQ5
      else $error("Call completion held for more than one cycle");

   // Clear checks
   a_file_clear_write: assert property (s_file_clear_taken |=> // RQ6
      file_wr_en && file_wr_data == ccie_pkg::ZERO_DATA && file_wr_addr == $past(instr_word[4:0]))
      else $error("File clear did not write zero");
   a_file_clear_zero: assert property (s_file_clear_taken |=> s_zero_written) // RQ6
      else $error("File clear did not set the zero flag");
   a_acc_clear_write: assert property (s_acc_clear_taken |=> // RQ7
      acc_wr_en && acc_wr_data == ccie_pkg::ZERO_DATA && !file_wr_en)
      else $error("Accumulator clear did not write zero");
   a_acc_clear_zero: assert property (s_acc_clear_taken |=> s_zero_written) // RQ7
      else $error("Accumulator clear did not set the zero flag");
   a_zero_from_clear: assert property (zero_set |-> file_wr_en || acc_wr_en) // RQ5
      else $error("Zero flag raised without a clear");
   a_one_write_target: assert property (!(file_wr_en && acc_wr_en)) // RQ8
      else $error("Both clear writes raised together");

   // Stall, step and idle checks
   a_clear_one_cycle: assert property (take && op != ccie_pkg::CCIE_OP_CALL |=> // RQ8
      !busy && program_counter == $past(program_counter) + 11'h001)
      else $error("Clear did not finish in one cycle");
   a_other_no_write: assert property (take && op == ccie_pkg::CCIE_OP_OTHER |=> // RQ8
      !file_wr_en && !acc_wr_en && !zero_set)
      else $error("Unknown word raised a write");
   a_busy_holds_pc: assert property (busy |=> program_counter == $past(program_counter)) // RQ5
      else $error("Word taken during the second call cycle");
   a_busy_no_writes: assert property (busy |=> !file_wr_en && !acc_wr_en && !zero_set) // RQ5
      else $error("Write raised during the second call cycle");
   a_idle_holds_pc: assert property (!take |=> program_counter == $past(program_counter)) // RQ8
      else $error("Program counter moved with nothing taken");
endmodule
`default_nettype wire

// ### verif/ccie_exec_tb.sv
// Self-checking bench for the call and clear execution block, with a cycle model.
// Assumes ccie_pkg is compiled first and the design holds its return stack inside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module ccie_exec_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [ccie_pkg::INSTR_W-1:0] instr_word = 12'h000;
   logic [1:0] status_page = 2'h0;
   logic [ccie_pkg::PROG_CNT_W-1:0] program_counter, stack_top, exp_prog, exp_top;
   logic [ccie_pkg::FADDR_W-1:0] file_wr_addr, exp_addr;
   logic [ccie_pkg::DATA_W-1:0] file_wr_data, acc_wr_data;
   logic busy, call_done, file_wr_en, acc_wr_en, zero_set;
   logic exp_busy, exp_done, exp_fwe, exp_awe, exp_zero;
   logic started = 1'b0;
   logic last_call = 1'b0;
   logic [15:0] rnd = 16'd47928;
   logic [11:0] w;
   int err_count = 0;
   int checked = 0;

   always #10 core_clk = ~core_clk;

   ccie_exec u_ccie_exec (.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .status_page(status_page), .program_counter(program_counter),
      .stack_top(stack_top), .busy(busy), .call_done(call_done), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .acc_wr_en(acc_wr_en),
      .acc_wr_data(acc_wr_data), .zero_set(zero_set));

   function automatic ccie_pkg::ccie_op_t op_of(input logic [11:0] iw);
      if (iw[11:8] == 4'h9) return ccie_pkg::CCIE_OP_CALL;
      if (iw == 12'h040) return ccie_pkg::CCIE_OP_CLEAR_ACC;
      if (iw[11:5] == 7'h03) return ccie_pkg::CCIE_OP_CLEAR_FILE;
      return ccie_pkg::CCIE_OP_OTHER;
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Reference model: expected outputs after each edge
   always @(posedge core_clk) begin
      started <= 1'b1;
      exp_fwe <= 1'b0;
      exp_awe <= 1'b0;
      exp_zero <= 1'b0;
      exp_busy <= 1'b0;
      exp_done <= exp_busy && !sys_rst;
      if (sys_rst) begin
         exp_prog <= 11'h000;
         exp_top <= 11'h000;
         exp_addr <= 5'h00;
      end else if (instr_valid && !exp_busy) begin
         exp_prog <= exp_prog + 11'h001;
         case (op_of(instr_word))
            ccie_pkg::CCIE_OP_CALL: begin
               exp_top <= exp_prog + 11'h001;
               exp_prog <= {status_page, 1'b0, instr_word[7:0]};
               exp_busy <= 1'b1;
            end
            ccie_pkg::CCIE_OP_CLEAR_FILE: begin
               exp_fwe <= 1'b1;
               exp_addr <= instr_word[4:0];
               exp_zero <= 1'b1;
            end
            ccie_pkg::CCIE_OP_CLEAR_ACC: begin
               exp_awe <= 1'b1;
               exp_zero <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // Compare mid-cycle, where every registered output has settled
   always @(negedge core_clk) begin
      if (started) begin
         `CHK("program_counter", exp_prog, program_counter)
         `CHK("stack_top", exp_top, stack_top)
         `CHK("busy", exp_busy, busy)
         `CHK("call_done", exp_done, call_done)
         `CHK("file_wr_en", exp_fwe, file_wr_en)
         `CHK("file_wr_addr", exp_addr, file_wr_addr)
         `CHK("file_wr_data", 8'h00, file_wr_data)
         `CHK("acc_wr_en", exp_awe, acc_wr_en)
         `CHK("acc_wr_data", 8'h00, acc_wr_data)
         `CHK("zero_set", exp_zero, zero_set)
      end
   end

   // A call is held through its busy cycle, as the fetch side would
   task automatic put(input logic v, input logic [11:0] iw, input logic [1:0] p);
      @(posedge core_clk);
      if (last_call) @(posedge core_clk);
      instr_valid <= v;
      instr_word <= iw;
      status_page <= p;
      last_call = v && (op_of(iw) == ccie_pkg::CCIE_OP_CALL);
   endtask

   task automatic do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      instr_valid <= 1'b0;
      last_call = 1'b0;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask

   task automatic rand_run(input int n);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         case (rnd[1:0])
            2'h0: w = {4'h9, rnd[15:8]};
            2'h1: w = {7'h03, rnd[12:8]};
            2'h2: w = 12'h040;
            default: w = rnd[15:4];
         endcase
         put(rnd[2] | rnd[3], w, rnd[5:4]);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int p = 0; p < 4; p++) put(1'b1, 12'h9a5, p[1:0]);
      $display("test call pages done");
      put(1'b1, 12'h060, 2'h0);
      put(1'b1, 12'h07f, 2'h1);
      put(1'b1, 12'h040, 2'h2);
      put(1'b1, 12'h040, 2'h3);
      put(1'b0, 12'h9ff, 2'h3);
      $display("test corners done");
      put(1'b1, 12'h9ff, 2'h3);
      for (int i = 0; i < 257; i++) put(1'b1, 12'h040, 2'h0);
      $display("test counter wrap done");
      rand_run(2000);
      do_reset();
      rand_run(300);
      $display("test random with reset done");
      repeat (3) @(posedge core_clk);
      final_report();
   end
endmodule
`default_nettype wire
